// >>> rtl/fbc_top.sv
// Top: AHB-Lite register file and two independent flash block command engines
`timescale 1ns/1ns
// Function
// - Block-1 bit 31 clear blocks debug reads
// - Bit 30 clear protects pages 120 to 127
// - Bits 29:0 each protect four lower pages
// - Immediate protection acts upon write, no key
// - Deferred protection keyed, active after reset
// - Status bit 3 sets on completion with enable
// - Status bit 2 follows controller busy
// - Status bit 1 sets on failed command
// - Status bit 0 sets on completion, read-clears
// - Mode bit 4 enables completion interrupt
// - Mode bit 3 clear refuses erase/write
// - Wait states change only when both match
// - Block-1 data and address 16-bit RW
// - Signature 24-bit read-only, resets all ones
// - Command register decodes documented command codes
// - Commands 0x00-0x06 read back as 0x07
module fbc_top
  import fbc_pkg::*;
#(
  parameter int NUM_BLOCKS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in, // AHB slave select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size, only words used
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB slave ready
  output logic hresp_out, // AHB response, always OKAY
  input wire logic [15:0] blk0_addr_in, // Block-0 address from its own data path
  input wire logic [15:0] blk0_data_in, // Block-0 data from its own data path
  input wire logic [31:0] blk0_wprot_in, // Block-0 effective protection
  input wire logic [31:0] blk1_saved_prot_in, // Saved deferred protection from array
  input wire fbc_rsp_t [NUM_BLOCKS-1:0] flash_rsp_in, // Macro answers per block
  output fbc_req_t [NUM_BLOCKS-1:0] flash_req_out, // Macro requests per block
  output logic [NUM_BLOCKS-1:0] irq_out, // Completion interrupt per block
  output logic [1:0] flash_wait_out, // Applied wait states
  output logic dbg_read_allow_out // Debug port may read block 1
);

  // Decode an address into a register selector; used by read and write paths
  function automatic fbc_sel_t fbc_decode(input logic [31:0] a);
    if (a == FBC_B0_STATUS_ADDR) begin
      return FBC_SEL_B0_STATUS;
    end else if (a == FBC_B0_MODE_ADDR) begin
      return FBC_SEL_B0_MODE;
    end else if (a == FBC_B0_CMD_ADDR) begin
      return FBC_SEL_B0_CMD;
    end else if (a == FBC_B1_STATUS_ADDR) begin
      return FBC_SEL_B1_STATUS;
    end else if (a == FBC_B1_MODE_ADDR) begin
      return FBC_SEL_B1_MODE;
    end else if (a == FBC_B1_CMD_ADDR) begin
      return FBC_SEL_B1_CMD;
    end else if (a == FBC_B1_DATA_ADDR) begin
      return FBC_SEL_B1_DATA;
    end else if (a == FBC_B1_ADDR_ADDR) begin
      return FBC_SEL_B1_ADDR;
    end else if (a == FBC_B1_SIGN_ADDR) begin
      return FBC_SEL_B1_SIGN;
    end else if (a == FBC_B1_DPROT_ADDR) begin
      return FBC_SEL_B1_DPROT;
    end else if (a == FBC_B1_IPROT_ADDR) begin
      return FBC_SEL_B1_IPROT;
    end else begin
      return FBC_SEL_NONE;
    end
  endfunction : fbc_decode

  // Bus pipeline
  logic ap_valid_r; // Address phase taken, data phase pending
  logic ap_write_r; // Pending transfer is a write
  logic [31:0] ap_addr_r; // Pending transfer address
  fbc_sel_t dp_sel; // Selector of the data-phase register
  logic wr_en; // Write strobe at the end of the data phase
  logic rd_en; // Read strobe at the end of the data phase

  // Block-1 storage
  logic [15:0] b1_data_r; // Data register
  logic [15:0] b1_addr_r; // Address register
  logic [23:0] b1_sign_r; // Signature result
  logic [31:0] b1_dprot_r; // Deferred protection as written
  logic [31:0] b1_iprot_r; // Immediate protection
  logic [31:0] b1_dprot_act_r; // Deferred protection in force since reset
  logic prot_load_r; // High until saved protection has been caught

  // Per-block registers
  logic [NUM_BLOCKS-1:0][7:0] mode_r; // Mode registers
  logic [NUM_BLOCKS-1:0][7:0] cmd_r; // Command registers
  logic [NUM_BLOCKS-1:0][2:0] flag_r; // Sticky irq, fail, done flags
  logic [NUM_BLOCKS-1:0] st_rd; // Status register read strobe
  logic [NUM_BLOCKS-1:0] mode_wr; // Mode register write strobe
  logic [NUM_BLOCKS-1:0] cmd_wr; // Command register write strobe
  logic [NUM_BLOCKS-1:0] start; // Accepted command start
  logic [NUM_BLOCKS-1:0] busy; // Engine busy
  logic [NUM_BLOCKS-1:0] done; // Engine completion pulse
  logic [NUM_BLOCKS-1:0] fail; // Engine outcome
  logic [NUM_BLOCKS-1:0][23:0] eng_rdata; // Engine results
  logic [NUM_BLOCKS-1:0][15:0] eng_addr; // Address per block
  logic [NUM_BLOCKS-1:0][15:0] eng_data; // Data per block
  logic [NUM_BLOCKS-1:0][31:0] eng_wprot; // Protection per block
  logic [NUM_BLOCKS-1:0][7:0] run_cmd_r; // Command being executed
  logic [31:0] rd_mux; // Read data selected for the data phase

  assign dp_sel = fbc_decode(ap_addr_r);
  assign wr_en = ap_valid_r && ap_write_r;
  assign rd_en = ap_valid_r && !ap_write_r;

  // Per-block strobes, index 0 and 1 map onto the two register groups
  assign st_rd[0] = rd_en && (dp_sel == FBC_SEL_B0_STATUS);
  assign st_rd[1] = rd_en && (dp_sel == FBC_SEL_B1_STATUS);
  assign mode_wr[0] = wr_en && (dp_sel == FBC_SEL_B0_MODE);
  assign mode_wr[1] = wr_en && (dp_sel == FBC_SEL_B1_MODE);
  assign cmd_wr[0] = wr_en && (dp_sel == FBC_SEL_B0_CMD);
  assign cmd_wr[1] = wr_en && (dp_sel == FBC_SEL_B1_CMD);
  assign eng_addr[0] = blk0_addr_in;
  assign eng_addr[1] = b1_addr_r;
  assign eng_data[0] = blk0_data_in;
  assign eng_data[1] = b1_data_r;
  assign eng_wprot[0] = blk0_wprot_in;
  assign eng_wprot[1] = b1_iprot_r & b1_dprot_act_r;

  // Address phase capture; one wait state keeps read data registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else if (hsel_in && hready_in && htrans_in[1]) begin
      ap_valid_r <= 1'b1;
      ap_write_r <= hwrite_in;
      ap_addr_r <= haddr_in;
      hreadyout_out <= 1'b0;
    end else if (ap_valid_r) begin
      ap_valid_r <= 1'b0;
      hreadyout_out <= 1'b1;
    end
  end

  // Read multiplexer; unmapped addresses and bits above each register's width read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_sel == FBC_SEL_B0_STATUS) begin
      rd_mux = {28'h000_0000, flag_r[0][2], busy[0], flag_r[0][1:0]};
    end else if (dp_sel == FBC_SEL_B0_MODE) begin
      rd_mux = {24'h00_0000, mode_r[0]};
    end else if (dp_sel == FBC_SEL_B0_CMD) begin
      rd_mux = {24'h00_0000, cmd_r[0]};
    end else if (dp_sel == FBC_SEL_B1_STATUS) begin
      rd_mux = {28'h000_0000, flag_r[1][2], busy[1], flag_r[1][1:0]};
    end else if (dp_sel == FBC_SEL_B1_MODE) begin
      rd_mux = {24'h00_0000, mode_r[1]};
    end else if (dp_sel == FBC_SEL_B1_CMD) begin
      rd_mux = {24'h00_0000, cmd_r[1]};
    end else if (dp_sel == FBC_SEL_B1_DATA) begin
      rd_mux = {16'h0000, b1_data_r};
    end else if (dp_sel == FBC_SEL_B1_ADDR) begin
      rd_mux = {16'h0000, b1_addr_r};
    end else if (dp_sel == FBC_SEL_B1_SIGN) begin
      rd_mux = {8'h00, b1_sign_r};
    end else if (dp_sel == FBC_SEL_B1_DPROT) begin
      rd_mux = b1_dprot_r;
    end else if (dp_sel == FBC_SEL_B1_IPROT) begin
      rd_mux = b1_iprot_r;
    end
  end

  // Read data register, loaded at the end of the data phase
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata_out <= rd_mux;
    end
  end

  // Block-1 data and address; read commands reload the data register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b1_data_r <= FBC_DATA_RST;
      b1_addr_r <= FBC_ADDR_RST;
    end else begin
      if (done[1] && run_cmd_r[1] == FBC_CMD_READ && !fail[1]) begin
        b1_data_r <= eng_rdata[1][15:0];
      end else if (wr_en && dp_sel == FBC_SEL_B1_DATA) begin
        b1_data_r <= hwdata_in[15:0];
      end
      if (wr_en && dp_sel == FBC_SEL_B1_ADDR) begin
        b1_addr_r <= hwdata_in[15:0];
      end
    end
  end

  // Signature: software cannot write it, only the signature command fills it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b1_sign_r <= FBC_SIGN_RST;
    end else if (done[1] && run_cmd_r[1] == FBC_CMD_SIGNATURE && !fail[1]) begin
      b1_sign_r <= eng_rdata[1];
    end
  end

  // Protection registers; immediate copy acts at once, deferred copy only as written
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b1_dprot_r <= FBC_DPROT_RST;
      b1_iprot_r <= FBC_IPROT_RST;
    end else begin
      if (wr_en && dp_sel == FBC_SEL_B1_DPROT) begin
        b1_dprot_r <= hwdata_in;
      end
      if (wr_en && dp_sel == FBC_SEL_B1_IPROT) begin
        b1_iprot_r <= hwdata_in;
      end
    end
  end

  // Saved protection is caught once, on the first edge after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prot_load_r <= 1'b1;
      b1_dprot_act_r <= FBC_DPROT_RST;
    end else if (prot_load_r) begin
      prot_load_r <= 1'b0;
      b1_dprot_act_r <= blk1_saved_prot_in;
    end
  end

  // Debug read permission; both protection levels must allow it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_read_allow_out <= 1'b0;
    end else begin
      dbg_read_allow_out <= eng_wprot[1][FBC_READ_PROT_BIT];
    end
  end

  // Wait states move only once both blocks agree, so a half-done update is harmless
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_wait_out <= FBC_WAIT_RST;
    end else if (mode_r[0][FBC_MD_WAIT_LSB +: 2] == mode_r[1][FBC_MD_WAIT_LSB +: 2]) begin
      flash_wait_out <= mode_r[0][FBC_MD_WAIT_LSB +: 2];
    end
  end

  // Per-block registers and engines, each block kept fully separate
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
      // Commands written while the engine is busy are dropped
      assign start[gi] = cmd_wr[gi] && !busy[gi];

      // Mode register, stored as written; software keeps the reserved bits low
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          mode_r[gi] <= FBC_MODE_RST;
        end else if (mode_wr[gi]) begin
          mode_r[gi] <= hwdata_in[7:0];
        end
      end

      // Command register and the code under execution
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cmd_r[gi] <= FBC_CMD_RST;
          run_cmd_r[gi] <= FBC_CMD_RST;
        end else if (start[gi]) begin
          cmd_r[gi] <= hwdata_in[7:0];
          run_cmd_r[gi] <= hwdata_in[7:0];
        end else if (done[gi] && run_cmd_r[gi] <= FBC_CMD_MASS_ERASE) begin
          cmd_r[gi] <= FBC_CMD_READBACK;
        end
      end

      // Sticky flags: a completion in the same cycle as a status read wins
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          flag_r[gi] <= (gi == 0) ? {FBC_B0_STATUS_RST[FBC_ST_IRQ], FBC_B0_STATUS_RST[1:0]} :
                                    {FBC_B1_STATUS_RST[FBC_ST_IRQ], FBC_B1_STATUS_RST[1:0]};
        end else begin
          flag_r[gi][2] <= (flag_r[gi][2] && !st_rd[gi]) ||
                           (done[gi] && mode_r[gi][FBC_MD_IRQ_EN]);
          flag_r[gi][FBC_ST_FAIL] <= (flag_r[gi][FBC_ST_FAIL] && !st_rd[gi]) ||
                                     (done[gi] && fail[gi]);
          flag_r[gi][FBC_ST_DONE] <= (flag_r[gi][FBC_ST_DONE] && !st_rd[gi]) || done[gi];
        end
      end

      // Interrupt line follows the interrupt status flag of its own block
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_out[gi] <= 1'b0;
        end else begin
          irq_out[gi] <= (flag_r[gi][2] && !st_rd[gi]) || (done[gi] && mode_r[gi][FBC_MD_IRQ_EN]);
        end
      end

      // Command engine of this block
      fbc_engine u_engine (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(start[gi]),
        .cmd_in(hwdata_in[7:0]),
        .mode_in(mode_r[gi]),
        .addr_in(eng_addr[gi]),
        .data_in(eng_data[gi]),
        .wprot_in(eng_wprot[gi]),
        .rsp_in(flash_rsp_in[gi]),
        .req_out(flash_req_out[gi]),
        .busy_out(busy[gi]),
        .done_out(done[gi]),
        .fail_out(fail[gi]),
        .rdata_out(eng_rdata[gi])
      );
    end
  endgenerate

endmodule : fbc_top

// >>> rtl/fbc_pkg.sv
// Package: register map, field positions, reset values and types for the flash block control
package fbc_pkg;

  // Register byte addresses
  localparam logic [31:0] FBC_B0_STATUS_ADDR = 32'hffff_0e00;
  localparam logic [31:0] FBC_B0_MODE_ADDR = 32'hffff_0e04;
  localparam logic [31:0] FBC_B0_CMD_ADDR = 32'hffff_0e08;
  localparam logic [31:0] FBC_B1_STATUS_ADDR = 32'hffff_0e80;
  localparam logic [31:0] FBC_B1_MODE_ADDR = 32'hffff_0e84;
  localparam logic [31:0] FBC_B1_CMD_ADDR = 32'hffff_0e88;
  localparam logic [31:0] FBC_B1_DATA_ADDR = 32'hffff_0e8c;
  localparam logic [31:0] FBC_B1_ADDR_ADDR = 32'hffff_0e90;
  localparam logic [31:0] FBC_B1_SIGN_ADDR = 32'hffff_0e98;
  localparam logic [31:0] FBC_B1_DPROT_ADDR = 32'hffff_0e9c;
  localparam logic [31:0] FBC_B1_IPROT_ADDR = 32'hffff_0ea0;

  // Values after reset
  localparam logic [3:0] FBC_B0_STATUS_RST = 4'h1;
  localparam logic [3:0] FBC_B1_STATUS_RST = 4'h0;
  localparam logic [7:0] FBC_MODE_RST = 8'h80;
  localparam logic [7:0] FBC_CMD_RST = 8'h00;
  localparam logic [15:0] FBC_DATA_RST = 16'h0000;
  localparam logic [15:0] FBC_ADDR_RST = 16'h0000;
  localparam logic [23:0] FBC_SIGN_RST = 24'hff_ffff;
  localparam logic [31:0] FBC_DPROT_RST = 32'h0000_0000;
  localparam logic [31:0] FBC_IPROT_RST = 32'h0fff_ffff;
  localparam logic [1:0] FBC_WAIT_RST = 2'h0;

  // Status bit positions
  localparam int FBC_ST_DONE = 0;
  localparam int FBC_ST_FAIL = 1;
  localparam int FBC_ST_BUSY = 2;
  localparam int FBC_ST_IRQ = 3;

  // Mode bit positions
  localparam int FBC_MD_WAIT_LSB = 0;
  localparam int FBC_MD_WR_EN = 3;
  localparam int FBC_MD_IRQ_EN = 4;
  localparam int FBC_MD_KEY_SEL = 5;
  localparam int FBC_MD_KEY_EN = 6;

  // Protection layout: 512-byte pages, groups of four pages
  localparam int FBC_PAGE_LSB = 9;
  localparam int FBC_GROUP_LSB = 11;
  localparam logic [6:0] FBC_TOP_PAGE_FIRST = 7'd120;
  localparam int FBC_TOP_PROT_BIT = 30;
  localparam int FBC_READ_PROT_BIT = 31;

  // Command register reads this after commands 0x00 to 0x06
  localparam logic [7:0] FBC_CMD_READBACK = 8'h07;

  // Command codes
  typedef enum logic [7:0] {
    FBC_CMD_NULL = 8'h00,
    FBC_CMD_READ = 8'h01,
    FBC_CMD_WRITE = 8'h02,
    FBC_CMD_ERASE_WRITE = 8'h03,
    FBC_CMD_VERIFY = 8'h04,
    FBC_CMD_PAGE_ERASE = 8'h05,
    FBC_CMD_MASS_ERASE = 8'h06,
    FBC_CMD_SIGNATURE = 8'h0b,
    FBC_CMD_PROTECT = 8'h0c,
    FBC_CMD_PING = 8'h0f
  } fbc_cmd_t;

  // Command engine states
  typedef enum logic [1:0] {
    FBC_ENG_IDLE = 2'b00,
    FBC_ENG_WAIT = 2'b01
  } fbc_eng_state_t;

  // Register selector produced by the address decoder
  typedef enum logic [3:0] {
    FBC_SEL_NONE = 4'h0,
    FBC_SEL_B0_STATUS = 4'h1,
    FBC_SEL_B0_MODE = 4'h2,
    FBC_SEL_B0_CMD = 4'h3,
    FBC_SEL_B1_STATUS = 4'h4,
    FBC_SEL_B1_MODE = 4'h5,
    FBC_SEL_B1_CMD = 4'h6,
    FBC_SEL_B1_DATA = 4'h7,
    FBC_SEL_B1_ADDR = 4'h8,
    FBC_SEL_B1_SIGN = 4'h9,
    FBC_SEL_B1_DPROT = 4'ha,
    FBC_SEL_B1_IPROT = 4'hb
  } fbc_sel_t;

  // Request to the flash array macro of one block
  typedef struct packed {
    logic valid;
    logic [7:0] op;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fbc_req_t;

  // Answer from the flash array macro of one block
  typedef struct packed {
    logic done;
    logic fail;
    logic [23:0] rdata;
  } fbc_rsp_t;

endpackage : fbc_pkg

// >>> rtl/fbc_engine.sv
// Per-block command engine: checks, issues and completes one flash command at a time
`timescale 1ns/1ns
module fbc_engine
  import fbc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in, // One-cycle command start
  input wire logic [7:0] cmd_in, // Command code
  input wire logic [7:0] mode_in, // Block mode register
  input wire logic [15:0] addr_in, // Flash byte address
  input wire logic [15:0] data_in, // Write or compare data
  input wire logic [31:0] wprot_in, // Effective protection, bit clear means protected
  input wire fbc_rsp_t rsp_in, // Macro answer
  output fbc_req_t req_out, // Macro request, registered
  output logic busy_out, // Engine owns the macro
  output logic done_out, // One-cycle completion pulse
  output logic fail_out, // Outcome of the completing command
  output logic [23:0] rdata_out // Read or signature result
);

  fbc_eng_state_t state_r; // Engine state
  logic is_wr_class; // Command alters the array
  logic page_locked; // Addressed page protected
  logic [6:0] page; // Addressed page number
  logic refuse; // Command fails without touching the macro
  logic local_done; // Completes at once with no macro access

  // Page protection lookup: top eight pages share one bit, the rest go in fours
  always_comb begin
    page = addr_in[FBC_PAGE_LSB +: 7];
    if (page >= FBC_TOP_PAGE_FIRST) begin
      page_locked = ~wprot_in[FBC_TOP_PROT_BIT];
    end else begin
      page_locked = ~wprot_in[addr_in[FBC_GROUP_LSB +: 5]];
    end
  end

  // Command screening before anything reaches the macro
  always_comb begin
    is_wr_class = (cmd_in == FBC_CMD_WRITE) || (cmd_in == FBC_CMD_ERASE_WRITE) ||
                  (cmd_in == FBC_CMD_PAGE_ERASE) || (cmd_in == FBC_CMD_MASS_ERASE);
    local_done = (cmd_in == FBC_CMD_NULL) || (cmd_in == FBC_CMD_PING);
    refuse = 1'b0;
    if (is_wr_class && !mode_in[FBC_MD_WR_EN]) begin
      refuse = 1'b1;
    end else if (is_wr_class && cmd_in != FBC_CMD_MASS_ERASE && page_locked) begin
      refuse = 1'b1; // Protected page
    end else if (cmd_in == FBC_CMD_PROTECT &&
                 !(mode_in[FBC_MD_KEY_EN] && !mode_in[FBC_MD_KEY_SEL])) begin
      refuse = 1'b1; // Key entry not armed
    end else if (!is_wr_class && !local_done && cmd_in != FBC_CMD_READ && cmd_in != FBC_CMD_VERIFY &&
                 cmd_in != FBC_CMD_SIGNATURE && cmd_in != FBC_CMD_PROTECT) begin
      refuse = 1'b1; // Reserved code
    end
  end

  // Sequencer: idle, or waiting for the macro to answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= FBC_ENG_IDLE;
      req_out <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      fail_out <= 1'b0;
      rdata_out <= 24'h00_0000;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        FBC_ENG_IDLE: begin
          if (start_in) begin
            if (refuse || local_done) begin
              done_out <= 1'b1;
              fail_out <= refuse;
            end else begin
              // Key for protect travels as address then data
              req_out.valid <= 1'b1;
              req_out.op <= cmd_in;
              req_out.addr <= addr_in;
              req_out.wdata <= {addr_in, data_in};
              busy_out <= 1'b1;
              state_r <= FBC_ENG_WAIT;
            end
          end
        end
        FBC_ENG_WAIT: begin
          if (rsp_in.done) begin
            req_out.valid <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            fail_out <= rsp_in.fail;
            rdata_out <= rsp_in.rdata;
            state_r <= FBC_ENG_IDLE;
          end
        end
        default: begin
          state_r <= FBC_ENG_IDLE;
        end
      endcase
    end
  end

endmodule : fbc_engine

// >>> verification/fbc_top_assertions.sv
// Checker: bus wait state, macro handshake and status read relations of the flash block control
`timescale 1ns/1ns
module fbc_top_sva
  import fbc_pkg::*;
#(
  parameter int NUM_BLOCKS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire fbc_rsp_t [NUM_BLOCKS-1:0] flash_rsp_in,
  input wire fbc_req_t [NUM_BLOCKS-1:0] flash_req_out
);
  logic take; // Transfer accepted at this edge
  logic st_q, cmd_q, sig_q; // Data phase of a block-1 status read, command write, signature read
  assign take = hsel_in && hready_in && htrans_in[1];
  // Remember what the pending data phase is for
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= 1'b0;
      cmd_q <= 1'b0;
      sig_q <= 1'b0;
    end else begin
      st_q <= take && !hwrite_in && haddr_in == FBC_B1_STATUS_ADDR;
      cmd_q <= take && hwrite_in && haddr_in == FBC_B1_CMD_ADDR;
      sig_q <= take && !hwrite_in && haddr_in == FBC_B1_SIGN_ADDR;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_one_wait: assert property (take |=> !hreadyout_out ##1 hreadyout_out) else $error("wait state not one cycle");
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  a_req_held: assert property (flash_req_out[1].valid && !flash_rsp_in[1].done
    |=> flash_req_out[1].valid && $stable(flash_req_out[1].op)) else $error("request dropped early");
  a_req_ends: assert property (flash_req_out[1].valid && flash_rsp_in[1].done
    |=> !flash_req_out[1].valid) else $error("request outlives answer");
  a_req_cause: assert property ($rose(flash_req_out[1].valid) |-> $past(cmd_q)) else $error("request without command");
  a_busy_shown: assert property (st_q && flash_req_out[1].valid && !flash_rsp_in[1].done
    |=> hrdata_out[FBC_ST_BUSY]) else $error("busy flag missing");
  a_status_rsvd: assert property (st_q |=> hrdata_out[31:4] == 28'h000_0000) else $error("status upper bits set");
  a_sign_width: assert property (sig_q |=> hrdata_out[31:24] == 8'h00) else $error("signature too wide");
  c_macro_cmd: cover property ($rose(flash_req_out[1].valid));
  c_busy_read: cover property (st_q && flash_req_out[1].valid);
  c_sign_read: cover property (sig_q);
endmodule : fbc_top_sva
bind fbc_top fbc_top_sva #(.NUM_BLOCKS(NUM_BLOCKS)) fbc_top_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .flash_rsp_in(flash_rsp_in), .flash_req_out(flash_req_out));

// >>> verification/fbc_top_tb.sv
// Testbench: register and command checks of the flash block control over AHB-Lite
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module fbc_top_tb
  import fbc_pkg::*;
;
  logic clk_in, rst_n_in, hsel, hwrite, hready, stall, dbg, resp;
  logic [1:0] htrans, irq, wst;
  logic [31:0] haddr, hwdata, hrdata, q, sprot;
  fbc_rsp_t [1:0] rsp = {2{1'b0, 1'b0, 24'h5a_a5c3}}; // Flash macro answers driven here
  fbc_req_t [1:0] req;
  int checks, n_mismatch, cyc;
  logic [7:0] cc [9] = '{8'h0f, 8'h00, 8'h07, 8'h0c, 8'h0b, 8'h01, 8'h04, 8'h03, 8'h06}; // Command sweep
  logic [7:0] ee [9] = '{8'h09, 8'h09, 8'h0b, 8'h0b, 8'h09, 8'h09, 8'h09, 8'h09, 8'h09}; // Status after each
  // Deferred protection saved as fully open, so immediate protection decides
  fbc_top fbc_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(resp), .blk0_addr_in(16'h0000), .blk0_data_in(16'h0000),
    .blk0_wprot_in(32'hffff_ffff), .blk1_saved_prot_in(sprot), .flash_rsp_in(rsp), .flash_req_out(req),
    .irq_out(irq), .flash_wait_out(wst), .dbg_read_allow_out(dbg));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Macro stand-in: one-cycle done pulse a cycle after a request, held off while stalled
  always @(posedge clk_in) begin
    for (int b = 0; b < 2; b++) rsp[b].done <= req[b].valid && !rsp[b].done && !stall;
  end
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // One single AHB transfer; o is the byte offset in the register page
  task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= FBC_B0_STATUS_ADDR + {24'h00_0000, o};
    hwrite <= w;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    bus(1'b1, o, d);
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, o, 32'h0000_0000);
    `CHK(q, e)
  endtask : rd
  // Block-1 command, then room for it to finish
  task automatic cmd(input logic [7:0] c);
    wr(8'h88, {24'h00_0000, c});
    repeat (5) @(posedge clk_in);
  endtask : cmd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {rst_n_in, hsel, hwrite, stall, htrans, haddr, hwdata} = '0;
    sprot = 32'hffff_ffff;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(8'h04, 32'h0000_0080);
    rd(8'h80, 32'h0000_0000);
    rd(8'ha0, 32'h0fff_ffff);
    rd(8'h88, 32'h0000_0000);
    rd(8'h90, 32'h0000_0000);
    wr(8'h98, 32'h0000_0000);
    rd(8'h98, 32'h00ff_ffff);
    wr(8'h8c, 32'h0000_1234);
    wr(8'h90, 32'h0000_f000);
    rd(8'h8c, 32'h0000_1234);
    rd(8'h90, 32'h0000_f000);
    wr(8'h9c, 32'h0000_0001);
    rd(8'h9c, 32'h0000_0001);
    `CHK(dbg, 1'b0)
    wr(8'h84, 32'h0000_0010);
    cmd(8'h02);
    `CHK(irq[1], 1'b1)
    rd(8'h80, 32'h0000_000b);
    `CHK(irq[1], 1'b0)
    rd(8'h80, 32'h0000_0000);
    rd(8'h88, 32'h0000_0007);
    wr(8'h84, 32'h0000_0018);
    cmd(8'h02);
    rd(8'h80, 32'h0000_000b);
    wr(8'ha0, 32'hffff_fffe);
    repeat (2) @(posedge clk_in);
    `CHK(dbg, 1'b1)
    wr(8'h90, 32'h0000_0600);
    cmd(8'h05);
    rd(8'h80, 32'h0000_000b);
    wr(8'h90, 32'h0000_0800);
    stall <= 1'b1;
    wr(8'h88, 32'h0000_0005);
    rd(8'h80, 32'h0000_0004);
    `CHK(req[1].op, 8'h05)
    stall <= 1'b0;
    repeat (5) @(posedge clk_in);
    rd(8'h80, 32'h0000_0009);
    for (int i = 0; i < 9; i++) begin
      cmd(cc[i]);
      rd(8'h80, {24'h00_0000, ee[i]});
    end
    rd(8'h98, 32'h005a_a5c3);
    rd(8'h8c, 32'h0000_a5c3);
    wr(8'h84, 32'h0000_0048);
    wr(8'h90, 32'h0000_00aa);
    wr(8'h8c, 32'h0000_0055);
    cmd(8'h0c);
    rd(8'h80, 32'h0000_0001);
    `CHK(req[1].wdata, 32'h00aa_0055)
    `CHK(irq[1], 1'b0)
    rd(8'h00, 32'h0000_0001);
    `CHK(irq[0], 1'b0)
    wr(8'h08, 32'h0000_000f);
    rd(8'h00, 32'h0000_0001);
    rd(8'h80, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    wr(8'h84, 32'h0000_0012);
    repeat (2) @(posedge clk_in);
    `CHK(wst, 2'h0)
    wr(8'h84, 32'h0000_0011);
    repeat (2) @(posedge clk_in);
    `CHK(wst, 2'h1)
    sprot <= 32'h7fff_ffff;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(8'ha0, 32'hffff_ffff);
    repeat (2) @(posedge clk_in);
    `CHK(dbg, 1'b0)
    wr(8'h94, 32'h0000_0005);
    rd(8'h94, 32'h0000_0000);
    give_verdict();
  end
endmodule : fbc_top_tb
